// file: logic/monitor_pkg.sv
// Purpose: shared constants for the pack monitor control bank
// Assumes: 100 MHz clock, 10 us protection tick
// Notes: delay tables are held in microseconds and seconds, converted to 10 us ticks in the bank
package monitor_pkg;
	// register offsets
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
	localparam logic [7:0] ADDR_CTRL_TWO = 8'h05;
	localparam logic [7:0] ADDR_SHORT_CFG = 8'h06;
	localparam logic [7:0] ADDR_OVERCUR_CFG = 8'h07;
	localparam logic [7:0] ADDR_DELAY_CFG = 8'h08;
	localparam logic [7:0] ADDR_HIGH_TRIP = 8'h09;
	localparam logic [7:0] ADDR_LOW_TRIP = 8'h0A;
	localparam logic [7:0] ADDR_TUNING = 8'h0B;
	// reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_DELAY_CFG = 8'h08;
	localparam logic [7:0] RST_HIGH_TRIP = 8'hAC;
	localparam logic [7:0] RST_LOW_TRIP = 8'h97;
	// field positions
	localparam int BIT_LOAD = 7;
	localparam int BIT_ADC_EN = 4;
	localparam int BIT_TSEL = 3;
	localparam int BIT_BYPASS = 7;
	localparam int BIT_CONT = 6;
	localparam int BIT_SHOT = 5;
	localparam int BIT_DSG = 1;
	localparam int BIT_CHG = 0;
	localparam int BIT_RANGE = 7;
	localparam int BIT_FRESH = 7;
	localparam int BIT_LOWF = 3;
	localparam int BIT_HIGHF = 2;
	localparam int BIT_SHORTF = 1;
	localparam int BIT_OCF = 0;
	// write masks of the writable bits
	localparam logic [7:0] MASK_CTRL_ONE = 8'h1F;
	localparam logic [7:0] MASK_SHORT = 8'hBF;
	localparam logic [7:0] MASK_OVERCUR = 8'h7F;
	localparam logic [7:0] MASK_TUNING = 8'h3F;
	localparam logic [7:0] MASK_STATUS = 8'h8F;
	// trip code framing
	localparam logic [1:0] HIGH_TRIP_TOP = 2'h2;
	localparam logic [3:0] HIGH_TRIP_LOW = 4'h8;
	localparam logic [1:0] LOW_TRIP_TOP = 2'h1;
	localparam logic [3:0] LOW_TRIP_LOW = 4'h0;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 10;
	localparam int TICK_CYCLES_DFLT = TICK_US * CLK_MHZ;
	localparam int CONV_MS = 250;
	localparam int BYPASS_MS = 250;
	localparam int DELAY_W = 21;
	localparam logic [DELAY_W-1:0] CONV_TICKS =
		DELAY_W'(CONV_MS * 1000 / TICK_US);
	localparam logic [DELAY_W-1:0] BYPASS_TICKS =
		DELAY_W'(BYPASS_MS * 1000 / TICK_US);
	localparam int OC_BASE_MS = 10;
	localparam logic [DELAY_W-1:0] OC_BASE_TICKS =
		DELAY_W'(OC_BASE_MS * 1000 / TICK_US);
	localparam int SEC_TICKS = 1000000 / TICK_US;
	typedef logic [DELAY_W-1:0] delay_t;
	typedef logic [7:0] mv_t;
	// short circuit delays in microseconds
	localparam int SHORT_US [4] = '{70, 100, 200, 400};
	// cell fault delays in seconds
	localparam int LOW_S [4] = '{1, 4, 8, 16};
	localparam int HIGH_S [4] = '{1, 2, 4, 8};
	// thresholds in mV, lower and upper range
	localparam mv_t SHORT_LO_MV [8] = '{8'd22, 8'd33, 8'd44, 8'd56,
		8'd67, 8'd78, 8'd89, 8'd100};
	localparam mv_t SHORT_HI_MV [8] = '{8'd44, 8'd67, 8'd89, 8'd111,
		8'd133, 8'd155, 8'd178, 8'd200};
	localparam mv_t OC_LO_MV [16] = '{8'd8, 8'd11, 8'd14, 8'd17,
		8'd19, 8'd22, 8'd25, 8'd28, 8'd31, 8'd33, 8'd36, 8'd39,
		8'd42, 8'd44, 8'd47, 8'd50};
	localparam mv_t OC_HI_MV [16] = '{8'd17, 8'd22, 8'd28, 8'd33,
		8'd39, 8'd44, 8'd50, 8'd56, 8'd61, 8'd67, 8'd72, 8'd78,
		8'd83, 8'd89, 8'd94, 8'd100};
	// shutdown tracker states
	typedef enum logic [1:0]
	{
		SD_IDLE = 2'b00,
		SD_GOT_ZERO = 2'b01,
		SD_GOT_OTHER = 2'b10,
		SD_GOT_ONE = 2'b11
	} sd_state_t;
	localparam logic [1:0] SD_CODE_ZERO = 2'b00;
	localparam logic [1:0] SD_CODE_ONE = 2'b01;
	localparam logic [1:0] SD_CODE_TWO = 2'b10;
	localparam int FAULT_N = 4;
endpackage : monitor_pkg

// file: logic/fault_timer_if.sv
// Purpose: carries one protection condition and its delay
// Assumes: single clock domain
// Notes: owner drives condition and limit, timer answers trip
`timescale 1ns/1ps
interface fault_timer_if;
	import monitor_pkg::*;
	logic cond; // raw fault condition, level
	delay_t limit; // delay in ticks
	logic trip; // condition held for the full delay
	modport owner (output cond, output limit, input trip);
	modport timer (input cond, input limit, output trip);
endinterface : fault_timer_if

// file: logic/fault_timer.sv
// Purpose: persistence timer for one protection condition
// Assumes: tick is a one-cycle enable pulse
// Notes: trip stays high while the condition stays true
`timescale 1ns/1ps
module fault_timer
	import monitor_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic tick, // 10 us enable
	fault_timer_if.timer ft // condition in, trip out
);
	delay_t count; // ticks the condition has held

	// count while held, restart the moment it drops
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count <= '0;
			ft.trip <= 1'b0;
		end
		else if (!ft.cond)
		begin
			count <= '0;
			ft.trip <= 1'b0;
		end
		else if (tick && !ft.trip)
		begin
			// limit of one tick trips on the first tick after the condition rises
			if (count + delay_t'(1) >= ft.limit)
				ft.trip <= 1'b1;
			count <= count + delay_t'(1);
		end
	end
endmodule : fault_timer

// file: logic/shutdown_tracker.sv
// Purpose: watches shutdown bit writes for the sleep sequence
// Assumes: wr is a one-cycle pulse per host write
// Notes: sleep request is sticky until reset
`timescale 1ns/1ps
module shutdown_tracker
	import monitor_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic wr, // write to the shutdown bits
	input wire logic [1:0] code, // value written
	output logic sleep // enter deep sleep, level
);
	sd_state_t state; // progress through the sequence

	// step on each write, fall back when the order breaks
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state <= SD_IDLE;
			sleep <= 1'b0;
		end
		else if (wr)
		begin
			unique case (state)
				SD_IDLE:
					state <= (code == SD_CODE_ZERO) ? SD_GOT_ZERO : SD_IDLE;
				SD_GOT_ZERO:
					// any value but one continues
					state <= (code == SD_CODE_ONE) ? SD_IDLE : SD_GOT_OTHER;
				SD_GOT_OTHER:
					if (code == SD_CODE_ONE)
						state <= SD_GOT_ONE;
					else if (code == SD_CODE_ZERO)
						state <= SD_GOT_OTHER;
					else
						state <= SD_IDLE;
				SD_GOT_ONE:
					if (code == SD_CODE_TWO)
					begin
						sleep <= 1'b1;
						state <= SD_IDLE;
					end
					else if (code == SD_CODE_ZERO)
						state <= SD_GOT_ZERO;
					else
						state <= SD_IDLE;
			endcase
		end
	end
endmodule : shutdown_tracker

// file: logic/pack_monitor_control_bank.sv
// Purpose: control and protection register bank of the monitor
// Assumes: host writes arrive as one-cycle strobes from the serial
//          front end; converter codes are on this clock
// Notes: reads return data one cycle after the read strobe
// Notes on behaviour
// - load flag only while charge driver off
// - load flag read-only, clears by itself
// - converter enable gates conversions and high protection
// - thermal select picks die or thermistor results
// - sleep after shutdown writes 00,non-01,01,10
// - bypass uses 250 ms for all protections
// - continuous counting ignores single-shot trigger
// - single shot runs once, clears, sets fresh
// - single shot only when not continuous, not fresh
// - enable bits drive the gate outputs
// - range bit doubles short and overcurrent levels
// - short delay code picks 70 to 400 us
// - short level code picks eight thresholds
// - overcurrent delay is 10 ms times 2^code
// - overcurrent level code picks sixteen thresholds
// - low cell delay 1, 4, 8, 16 s
// - high cell delay 1, 2, 4, 8 s
// - high trip code is 10, bits, 1000
// - low trip code is 01, bits, 0000
// - faults latch, write one clears
`timescale 1ns/1ps
module pack_monitor_control_bank
	import monitor_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DFLT // clocks per 10 us
)
(
	input wire logic clk, // 100 MHz clock
	input wire logic rst, // async reset, high
	input wire logic reg_wr, // host write strobe
	input wire logic reg_rd, // host read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data
	input wire logic load_sense_level, // charge pin above level, async
	input wire logic [7:0] sense_mv, // discharge sense voltage, mV
	input wire logic [13:0] cell_code_max, // highest cell code
	input wire logic [13:0] cell_code_min, // lowest cell code
	input wire logic conv_done, // one-cycle conversion strobe
	input wire logic [13:0] die_temp_code, // die temperature code
	input wire logic [2:0][13:0] therm_code, // thermistor codes
	output logic [2:0][13:0] thermal_result, // stored temperatures
	output logic converter_enable, // run voltage conversions
	output logic counter_running, // coulomb counter active
	output logic charge_gate_output, // charge driver
	output logic discharge_gate_output, // discharge driver
	output logic deep_sleep_state, // power down request
	output logic [5:0] counter_tuning_bits // counter tuning
);
	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	// register storage
	logic [7:0] ctrl_one; // converter, thermal select, shutdown
	logic [7:0] ctrl_two; // bypass, counter, drivers
	logic [7:0] short_cfg; // range, short delay and level
	logic [7:0] overcur_cfg; // overcurrent delay and level
	logic [7:0] delay_cfg; // cell fault delays
	logic [7:0] high_trip; // high cell trip bits
	logic [7:0] low_trip; // low cell trip bits
	logic [7:0] tuning; // counter tuning
	logic [7:0] status; // sticky flags

	// decoded accesses
	logic wr_ctrl_one; // write to control one
	logic wr_ctrl_two; // write to control two
	logic wr_status; // write to status
	assign wr_ctrl_one = reg_wr && (reg_addr == ADDR_CTRL_ONE);
	assign wr_ctrl_two = reg_wr && (reg_addr == ADDR_CTRL_TWO);
	assign wr_status = reg_wr && (reg_addr == ADDR_STATUS);

	// protection tick divider
	logic [TICK_W-1:0] tick_cnt; // cycles within a tick
	logic tick; // one-cycle 10 us enable

	// free-running divider for all slow timing
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			tick_cnt <= '0;
			tick <= 1'b0;
		end
		else if (tick_cnt == TICK_W'(TICK_CYCLES - 1))
		begin
			tick_cnt <= '0;
			tick <= 1'b1;
		end
		else
		begin
			tick_cnt <= tick_cnt + TICK_W'(1);
			tick <= 1'b0;
		end
	end

	// load pin synchroniser, three stages
	logic load_s1; // first stage, only read by second
	logic load_s2; // second stage
	logic load_s3; // third stage
	logic load_seen; // filtered level

	// a change counts once stages two and three agree
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			load_s1 <= 1'b0;
			load_s2 <= 1'b0;
			load_s3 <= 1'b0;
			load_seen <= 1'b0;
		end
		else
		begin
			load_s1 <= load_sense_level;
			load_s2 <= load_s1;
			load_s3 <= load_s2;
			if (load_s2 == load_s3)
				load_seen <= load_s3;
		end
	end

	// load flag computed live, never stored
	logic load_flag; // external load present
	assign load_flag = load_seen && !ctrl_two[BIT_CHG];

	// control one: shutdown bits store as written
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_one <= RST_ZERO;
		else if (wr_ctrl_one)
			ctrl_one <= reg_wdata & MASK_CTRL_ONE;
	end

	// single-shot and continuous counting
	logic shot_busy; // a single conversion is in progress
	logic shot_done; // single conversion finished this cycle
	logic conv_end; // any counter conversion finished
	delay_t conv_cnt; // ticks into the current conversion
	logic shot_start; // accept the trigger

	assign shot_start = ctrl_two[BIT_SHOT] && !ctrl_two[BIT_CONT]
		&& !status[BIT_FRESH] && !shot_busy;
	assign conv_end = tick && (conv_cnt == CONV_TICKS - delay_t'(1));
	assign shot_done = shot_busy && conv_end;

	// conversion period counter, 250 ms per result
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			conv_cnt <= '0;
		else if (!(ctrl_two[BIT_CONT] || shot_busy))
			conv_cnt <= '0;
		else if (tick)
			conv_cnt <= conv_end ? '0 : conv_cnt + delay_t'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			shot_busy <= 1'b0;
		else if (shot_start)
			shot_busy <= 1'b1;
		else if (shot_done || ctrl_two[BIT_CONT])
			shot_busy <= 1'b0;
	end

	// control two; hardware clears the trigger at the end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ctrl_two <= RST_ZERO;
		else if (wr_ctrl_two)
			ctrl_two <= reg_wdata;
		else if (shot_done)
			ctrl_two[BIT_SHOT] <= 1'b0;
	end

	// protection and tuning configuration
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			short_cfg <= RST_ZERO;
			overcur_cfg <= RST_ZERO;
			delay_cfg <= RST_DELAY_CFG;
			high_trip <= RST_HIGH_TRIP;
			low_trip <= RST_LOW_TRIP;
			tuning <= RST_ZERO;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				ADDR_SHORT_CFG: short_cfg <= reg_wdata & MASK_SHORT;
				ADDR_OVERCUR_CFG: overcur_cfg <= reg_wdata & MASK_OVERCUR;
				// host is trusted to keep the low bits at default
				ADDR_DELAY_CFG: delay_cfg <= reg_wdata;
				ADDR_HIGH_TRIP: high_trip <= reg_wdata;
				ADDR_LOW_TRIP: low_trip <= reg_wdata;
				ADDR_TUNING: tuning <= reg_wdata & MASK_TUNING;
				default: ;
			endcase
		end
	end

	// threshold lookup, shared by both current comparators
	function automatic mv_t pick_mv(input logic upper, input mv_t lo,
		input mv_t hi);
		pick_mv = upper ? hi : lo;
	endfunction : pick_mv

	// field views
	logic range_up; // upper sense range
	logic [1:0] short_dly_code; // short_circuit_delay_code
	logic [2:0] short_lvl_code; // short_circuit_level_code
	logic [2:0] oc_dly_code; // overcurrent_delay_code
	logic [3:0] oc_lvl_code; // overcurrent_level_code
	logic [1:0] low_dly_code; // low_cell_delay_code
	logic [1:0] high_dly_code; // high_cell_delay_code
	logic bypass; // fault_delay_bypass
	assign range_up = short_cfg[BIT_RANGE];
	assign short_dly_code = short_cfg[4:3];
	assign short_lvl_code = short_cfg[2:0];
	assign oc_dly_code = overcur_cfg[6:4];
	assign oc_lvl_code = overcur_cfg[3:0];
	assign low_dly_code = delay_cfg[7:6];
	assign high_dly_code = delay_cfg[5:4];
	assign bypass = ctrl_two[BIT_BYPASS];

	// thresholds
	mv_t short_mv; // short circuit level
	mv_t oc_mv; // overcurrent level
	logic [13:0] high_code; // high cell trip code
	logic [13:0] low_code; // low cell trip code
	assign short_mv = pick_mv(range_up, SHORT_LO_MV[short_lvl_code],
		SHORT_HI_MV[short_lvl_code]);
	assign oc_mv = pick_mv(range_up, OC_LO_MV[oc_lvl_code],
		OC_HI_MV[oc_lvl_code]);
	assign high_code = {HIGH_TRIP_TOP, high_trip, HIGH_TRIP_LOW};
	assign low_code = {LOW_TRIP_TOP, low_trip, LOW_TRIP_LOW};

	// programmed delays in ticks
	delay_t dly [FAULT_N]; // per protection, before bypass
	assign dly[BIT_SHORTF] = delay_t'(SHORT_US[short_dly_code] / TICK_US);
	assign dly[BIT_OCF] = OC_BASE_TICKS << oc_dly_code;
	assign dly[BIT_LOWF] = delay_t'(LOW_S[low_dly_code] * SEC_TICKS);
	assign dly[BIT_HIGHF] = delay_t'(HIGH_S[high_dly_code] * SEC_TICKS);

	// raw conditions, indexed like the status bits
	logic [FAULT_N-1:0] cond; // fault present now
	assign cond[BIT_SHORTF] = sense_mv >= short_mv;
	assign cond[BIT_OCF] = sense_mv >= oc_mv;
	assign cond[BIT_HIGHF] = ctrl_one[BIT_ADC_EN]
		&& (cell_code_max > high_code);
	assign cond[BIT_LOWF] = cell_code_min < low_code;

	// one persistence timer per protection
	logic [FAULT_N-1:0] trip; // timer outputs
	logic [FAULT_N-1:0] trip_q; // last cycle's trips
	genvar gi;
	generate
		for (gi = 0; gi < FAULT_N; gi++)
		begin : g_fault
			fault_timer_if ftif ();
			assign ftif.cond = cond[gi];
			assign ftif.limit = bypass ? BYPASS_TICKS : dly[gi];
			assign trip[gi] = ftif.trip;
			fault_timer u_timer (
				.clk(clk),
				.rst(rst),
				.tick(tick),
				.ft(ftif)
			);
		end
	endgenerate

	// edge of each trip so a cleared flag is not reset while held
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			trip_q <= '0;
		else
			trip_q <= trip;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			status <= RST_ZERO;
		else
		begin
			// set wins over a clear in the same cycle
			status <= ((status & ~(wr_status ? reg_wdata : RST_ZERO))
				| {conv_end, 3'b000, trip & ~trip_q}) & MASK_STATUS;
		end
	end

	logic sleep_req; // tracker result
	shutdown_tracker u_shutdown (
		.clk(clk),
		.rst(rst),
		.wr(wr_ctrl_one),
		.code(reg_wdata[1:0]),
		.sleep(sleep_req)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			thermal_result <= '0;
		else if (conv_done && ctrl_one[BIT_ADC_EN])
		begin
			for (int i = 0; i < 3; i++)
				thermal_result[i] <= ctrl_one[BIT_TSEL] ? therm_code[i]
					: die_temp_code;
		end
	end

	// registered outputs
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			converter_enable <= 1'b0;
			counter_running <= 1'b0;
			charge_gate_output <= 1'b0;
			discharge_gate_output <= 1'b0;
			deep_sleep_state <= 1'b0;
			counter_tuning_bits <= '0;
		end
		else
		begin
			converter_enable <= ctrl_one[BIT_ADC_EN];
			counter_running <= ctrl_two[BIT_CONT] || shot_busy;
			charge_gate_output <= ctrl_two[BIT_CHG];
			discharge_gate_output <= ctrl_two[BIT_DSG];
			deep_sleep_state <= sleep_req;
			counter_tuning_bits <= tuning[5:0];
		end
	end

	// read mux; unmapped offsets answer zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			reg_rdata <= RST_ZERO;
		else if (reg_rd)
		begin
			unique case (reg_addr)
				ADDR_STATUS: reg_rdata <= status;
				ADDR_CTRL_ONE: reg_rdata <= {load_flag, ctrl_one[6:0]};
				ADDR_CTRL_TWO: reg_rdata <= ctrl_two;
				ADDR_SHORT_CFG: reg_rdata <= short_cfg;
				ADDR_OVERCUR_CFG: reg_rdata <= overcur_cfg;
				ADDR_DELAY_CFG: reg_rdata <= delay_cfg;
				ADDR_HIGH_TRIP: reg_rdata <= high_trip;
				ADDR_LOW_TRIP: reg_rdata <= low_trip;
				ADDR_TUNING: reg_rdata <= tuning;
				default: reg_rdata <= RST_ZERO;
			endcase
		end
	end
endmodule : pack_monitor_control_bank

// file: tb/bank_props.sv
// Purpose: port level checks of the pack monitor control bank
// Assumes: one-cycle strobes, host writes at least two cycles apart
// Notes: written bits reach the outputs two cycles after the write edge
`timescale 1ns/1ps
module bank_props
	import monitor_pkg::*;
(
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_addr, // register offset
	input wire logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata, // read data
	input wire logic converter_enable, // conversions on
	input wire logic counter_running, // counter active
	input wire logic charge_gate_output, // charge driver
	input wire logic discharge_gate_output, // discharge driver
	input wire logic deep_sleep_state, // sleep request
	input wire logic [5:0] counter_tuning_bits // tuning copy
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	charge_follow_a:
		assert property (reg_wr && reg_addr == ADDR_CTRL_TWO |-> ##2
			charge_gate_output == $past(reg_wdata[BIT_CHG], 2))
		else $error("charge gate not following its enable");
	gate_cause_a:
		assert property ($changed(discharge_gate_output) |->
			$past(reg_wr, 2) && $past(reg_addr, 2) == ADDR_CTRL_TWO)
		else $error("discharge gate moved without a write");
	converter_follow_a:
		assert property (reg_wr && reg_addr == ADDR_CTRL_ONE |-> ##2
			converter_enable == $past(reg_wdata[BIT_ADC_EN], 2))
		else $error("converter enable not following its bit");
	tuning_copy_a:
		assert property (reg_wr && reg_addr == ADDR_TUNING |-> ##2
			counter_tuning_bits == $past(reg_wdata[5:0], 2))
		else $error("tuning output not following its register");
	load_masked_a:
		assert property (reg_rd && reg_addr == ADDR_CTRL_ONE
			##1 charge_gate_output |-> !reg_rdata[BIT_LOAD])
		else $error("load flag seen while charge driver on");
	sleep_cause_a:
		assert property ($rose(deep_sleep_state) |-> $past(reg_wr, 2) &&
			$past(reg_addr, 2) == ADDR_CTRL_ONE &&
			$past(reg_wdata[1:0], 2) == SD_CODE_TWO)
		else $error("sleep entered without a final shutdown write");
	sleep_sticky_a:
		assert property (deep_sleep_state |=> deep_sleep_state)
		else $error("sleep request dropped");
	continuous_run_a:
		assert property (reg_wr && reg_addr == ADDR_CTRL_TWO &&
			reg_wdata[BIT_CONT] |-> ##[1:4] counter_running)
		else $error("counter not running in continuous mode");
	cover property ($rose(deep_sleep_state));
	cover property ($fell(counter_running));
	cover property (reg_rd && reg_addr == ADDR_STATUS ##1 reg_rdata[1]);
endmodule : bank_props

// file: tb/host_model.sv
// Purpose: host side of the register strobe port
// Assumes: design samples strobes on the rising clock edge
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
module host_model
	import monitor_pkg::*;
(
	input wire logic clk, // system clock
	output logic reg_wr, // write strobe
	output logic reg_rd, // read strobe
	output logic [7:0] reg_addr, // register offset
	output logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata // read data
);
	// idle bus at time zero
	initial
	begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
	end
	// one write, held over exactly one sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = (a == ADDR_DELAY_CFG) ? {d[7:4], RST_DELAY_CFG[3:0]} : d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask : wr
	// one read, data taken a full cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : host_model

// file: tb/pack_monitor_control_bank_test.sv
// Purpose: register level test of the pack monitor control bank
// Assumes: inputs change 1 ns after the rising edge
// Notes: tick cut to two clocks, so one shot lasts 50000 clocks
`timescale 1ns/1ps
module pack_monitor_control_bank_test;
	import monitor_pkg::*;
	logic clk, rst, reg_wr, reg_rd, load_sense_level, conv_done;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, sense_mv, rv;
	logic [13:0] die_temp_code, cell_code_max, cell_code_min; // codes
	logic [2:0][13:0] therm_code, thermal_result; // temperatures
	logic converter_enable, counter_running, deep_sleep_state;
	logic charge_gate_output, discharge_gate_output;
	logic [5:0] counter_tuning_bits; // tuning copy
	int err_count, samples_checked, n;
	// offsets, reset values, values after writing all ones
	logic [7:0] ta [10] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08,
		8'h09, 8'h0A, 8'h0B, 8'h0C};
	logic [7:0] tr [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h08,
		8'hAC, 8'h97, 8'h00, 8'h00};
	logic [7:0] tf [10] = '{8'h00, 8'h00, 8'h00, 8'hBF, 8'h7F, 8'hF8,
		8'hFF, 8'hFF, 8'h3F, 8'h00};
	// broken order first, then the accepted order
	logic [1:0] sd [8] = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b00, 2'b11,
		2'b01, 2'b10};
	// cell codes start inside both trip levels
	pack_monitor_control_bank #(.TICK_CYCLES(2)) pack_monitor_control_bank_i (
		.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.load_sense_level(load_sense_level), .sense_mv(sense_mv),
		.cell_code_max(cell_code_max), .cell_code_min(cell_code_min),
		.conv_done(conv_done), .die_temp_code(die_temp_code),
		.therm_code(therm_code), .thermal_result(thermal_result),
		.converter_enable(converter_enable),
		.counter_running(counter_running),
		.charge_gate_output(charge_gate_output),
		.discharge_gate_output(discharge_gate_output),
		.deep_sleep_state(deep_sleep_state),
		.counter_tuning_bits(counter_tuning_bits));
	host_model host_model_i (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [13:0] e,
		input logic [13:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask : cyc
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host_model_i.rd(a, rv);
		chk($sformatf("register %h", a), {6'h00, e}, {6'h00, rv});
	endtask : rchk
	// one conversion strobe, then results checked
	task automatic conv(input logic sel);
		conv_done = 1'b1;
		cyc(1);
		conv_done = 1'b0;
		cyc(2);
		for (int i = 0; i < 3; i++)
			chk("temperature", sel ? therm_code[i] : 14'h1ABC, thermal_result[i]);
	endtask : conv
	task automatic report_and_stop;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop
	// whole run is near 50500 clocks; 70000 clocks means a hang
	initial
	begin
		#700000;
		err_count++;
		report_and_stop();
	end
	initial
	begin
		{rst, load_sense_level, conv_done, sense_mv} = {3'b100, 8'h00};
		die_temp_code = 14'h1ABC;
		therm_code = {14'h0789, 14'h0456, 14'h0123};
		{cell_code_max, cell_code_min} = {14'h0000, 14'h3FFF};
		{err_count, samples_checked} = {32'd0, 32'd0};
		cyc(2);
		rst = 1'b0;
		// reset values, writable bits, unmapped offset
		for (int i = 0; i < 10; i++)
		begin
			rchk(ta[i], tr[i]);
			if (i > 2)
			begin
				host_model_i.wr(ta[i], 8'hFF);
				rchk(ta[i], tf[i]);
				host_model_i.wr(ta[i], tr[i]);
			end
		end
		// every enable pair reaches the gate drivers
		for (int i = 0; i < 4; i++)
		begin
			host_model_i.wr(8'h05, 8'(i));
			cyc(2);
			chk("gates", 14'(i), {12'h000, discharge_gate_output,
				charge_gate_output});
		end
		load_sense_level = 1'b1;
		cyc(6);
		rchk(8'h04, 8'h00);
		host_model_i.wr(8'h05, 8'h00);
		cyc(6);
		rchk(8'h04, 8'h80);
		load_sense_level = 1'b0;
		cyc(6);
		rchk(8'h04, 8'h00);
		host_model_i.wr(8'h0B, 8'h19);
		cyc(2);
		chk("tuning", 14'h0019, {8'h00, counter_tuning_bits});
		// short circuit at 22 mV after 7 ticks, then doubled range
		sense_mv = 8'd21;
		cyc(100);
		rchk(8'h00, 8'h00);
		sense_mv = 8'd22;
		cyc(8);
		rchk(8'h00, 8'h00);
		cyc(20);
		rchk(8'h00, 8'h02);
		sense_mv = 8'd0;
		host_model_i.wr(8'h00, 8'h02);
		rchk(8'h00, 8'h00);
		host_model_i.wr(8'h06, 8'h80);
		sense_mv = 8'd43;
		cyc(40);
		rchk(8'h00, 8'h00);
		sense_mv = 8'd44;
		cyc(40);
		rchk(8'h00, 8'h02);
		sense_mv = 8'd0;
		host_model_i.wr(8'h00, 8'h02);
		// thermistor then die source, then conversions off
		host_model_i.wr(8'h04, 8'h18);
		cyc(2);
		chk("converter", 14'h0001, {13'h0, converter_enable});
		conv(1'b1);
		host_model_i.wr(8'h04, 8'h10);
		conv(1'b0);
		die_temp_code = 14'h0555;
		host_model_i.wr(8'h04, 8'h00);
		conv(1'b0);
		die_temp_code = 14'h1ABC;
		// one shot of 25000 ticks, cell faults under bypass meanwhile
		host_model_i.wr(8'h04, 8'h10);
		// raw codes just past both trip levels
		{cell_code_max, cell_code_min} = {14'h2AC9, 14'h196F};
		host_model_i.wr(8'h05, 8'hA0);
		for (n = 0; counter_running !== 1'b1 && n < 10; n++)
			cyc(1);
		rchk(8'h00, 8'h00);
		for (n = 0; counter_running === 1'b1 && n < 60000; n++)
			cyc(1);
		chk("shot length", 14'h0001, {13'h0, n > 49990 && n < 50010});
		rchk(8'h05, 8'h80);
		rchk(8'h00, 8'h8C);
		host_model_i.wr(8'h05, 8'h20);
		cyc(8);
		chk("shot refused", 14'h0000, {13'h0, counter_running});
		host_model_i.wr(8'h05, 8'h60);
		cyc(4);
		chk("continuous", 14'h0001, {13'h0, counter_running});
		// shutdown codes, sleep only after the last accepted code
		for (int i = 0; i < 8; i++)
		begin
			host_model_i.wr(8'h04, {6'h00, sd[i]});
			cyc(2);
			chk("sleep", 14'(i == 7), {13'h0, deep_sleep_state});
		end
		report_and_stop();
	end
endmodule : pack_monitor_control_bank_test
bind pack_monitor_control_bank bank_props bank_props_i (.clk(clk),
	.rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.converter_enable(converter_enable), .counter_running(counter_running),
	.charge_gate_output(charge_gate_output),
	.discharge_gate_output(discharge_gate_output),
	.deep_sleep_state(deep_sleep_state),
	.counter_tuning_bits(counter_tuning_bits));
